// ---- imu_output_config_and_bit_tb_top.sv ----
// self-checking bench for the output configuration and test word block
// assumes imucfg_top with a shortened base tick of BASE cycles
`timescale 1ns/10ps
`include "imucfg_consts.svh"
module imu_output_config_and_bit_tb_top;
  localparam int BASE = 100;
  logic        clock_i = 0;
  logic        sys_rst_i = 1;
  logic [5:0]  avs_address_i = '0;
  logic        avs_read_i = 0;
  logic        avs_write_i = 0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0]  avs_byteenable_i = '0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [15:0] gyro_delta_i = '0;
  logic [2:0]  hw_error_i = '0;
  logic [3:0]  alert_i = '0;
  logic [15:0] subsys_status_i = '0;
  logic [1:0]  baud_sel_o;
  logic [7:0]  gyro_filt_o, accel_xy_filt_o, accel_z_filt_o;
  logic [4:0]  orient_o;
  logic        pkt_valid_o, pkt_delta_o, irq_o;
  logic [1:0]  pkt_kind_o;
  logic [15:0] pkt_bit_word_o, pkt_gyro_sum_o, pkt_diag_o;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [31:0] seed = 32'h10d8;
  logic [31:0] rd, v, e, a;
  logic [63:0] p;
  logic        m_fatal = 1'b0;
  int          m_baud = 2, m_fmt = 0, m_rate = 0, m_orient = 0, m_filt = 32'h191919;
  int          div[7] = '{1, 2, 4, 5, 10, 20, 50};

  imucfg_top #(.ACC_WIDTH(16), .BASE_CYCLES(BASE)) dut (
    .clock_i          (clock_i),
    .sys_rst_i        (sys_rst_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .gyro_delta_i     (gyro_delta_i),
    .hw_error_i       (hw_error_i),
    .alert_i          (alert_i),
    .subsys_status_i  (subsys_status_i),
    .baud_sel_o       (baud_sel_o),
    .gyro_filt_o      (gyro_filt_o),
    .accel_xy_filt_o  (accel_xy_filt_o),
    .accel_z_filt_o   (accel_z_filt_o),
    .orient_o         (orient_o),
    .pkt_valid_o      (pkt_valid_o),
    .pkt_kind_o       (pkt_kind_o),
    .pkt_delta_o      (pkt_delta_o),
    .pkt_bit_word_o   (pkt_bit_word_o),
    .pkt_gyro_sum_o   (pkt_gyro_sum_o),
    .pkt_diag_o       (pkt_diag_o),
    .irq_o            (irq_o)
  );
  imucfg_host_model host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .pkt_valid_i(pkt_valid_o),
    .pkt_kind_i(pkt_kind_o), .pkt_delta_i(pkt_delta_o), .pkt_bit_word_i(pkt_bit_word_o),
    .pkt_gyro_sum_i(pkt_gyro_sum_o), .pkt_diag_i(pkt_diag_o));

  always #5 clock_i = ~clock_i;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    n_checks++;
    if (g !== ex) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, g);
    end
  endtask

  // the request is held until waitrequest is sampled low or 20 cycles pass, never assumed
  task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] d, input logic [3:0] be = 4'hf);
    int n;
    @(posedge clock_i);
    avs_address_i <= ad;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    chk("bus answer", 1, n < 20);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wait_pkts(input int n, input int lim);
    int c;
    c = 0;
    while (host.p_q.size() < n && c < lim) begin
      @(posedge clock_i);
      c++;
    end
    chk("packet count", 1, host.p_q.size() >= n);
  endtask

  task automatic poll(input logic [31:0] c);
    host.p_q.delete();
    bus(1, `IMUCFG_OFS_CMD, c);
    wait_pkts(1, 10);
    p = host.p_q.size() > 0 ? host.p_q.pop_front() : '0;
  endtask

  task automatic setctrl(input int b, input int f, input int r);
    m_baud = b;
    m_fmt = f;
    m_rate = r;
    bus(1, `IMUCFG_OFS_CTRL, b | (f << 2) | (r << 4));
  endtask

  task automatic chk_cfg();
    chk("baud", m_baud, baud_sel_o);
    chk("gyro filter", m_filt[7:0], gyro_filt_o);
    chk("xy filter", m_filt[15:8], accel_xy_filt_o);
    chk("z filter", m_filt[23:16], accel_z_filt_o);
    chk("orientation", m_orient, orient_o);
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clock_i);
    miscompares++;
    results();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk_cfg();
    bus(0, `IMUCFG_OFS_CTRL, 0);
    chk("ctrl reset", 32'h2, rd);
    bus(0, `IMUCFG_OFS_ALERT_EN, 0);
    chk("alert enable reset", 32'h8, rd);
    host.p_q.delete();
    host.t_q.delete();
    wait_pkts(3, 4 * BASE);
    chk("default interval", BASE, host.t_q[2] - host.t_q[1]);
    chk("default kind", 1, host.p_q[0][50:49]);
    chk("default format", 0, host.p_q[0][48]);
    $display("test defaults done");
    // the streaming rate codes 0 to 6 also walk every baud code
    for (int r = 0; r < 7; r++) begin
      setctrl(r % 4, 0, r);
      host.p_q.delete();
      host.t_q.delete();
      wait_pkts(3, 3 * div[r] * BASE + 50);
      chk("rate interval", div[r] * BASE, host.t_q[2] - host.t_q[1]);
      chk_cfg();
    end
    $display("test rates done");
    setctrl(2, 0, 7);
    bus(1, `IMUCFG_OFS_IRQ_STAT, 32'h7);
    host.p_q.delete();
    repeat (3 * BASE) @(posedge clock_i);
    chk("quiet packets", 0, host.p_q.size());
    bus(1, `IMUCFG_OFS_IRQ_MASK, 32'h1);
    @(posedge clock_i);
    chk("irq idle", 0, irq_o);
    subsys_status_i <= rnd();
    poll(32'h1);
    chk("poll kind", 1, p[50:49]);
    chk("clean word", 0, p[47:32]);
    @(posedge clock_i);
    chk("irq raised", 1, irq_o);
    bus(0, `IMUCFG_OFS_IRQ_STAT, 0);
    chk("irq status", 1, rd & 32'h1);
    bus(1, `IMUCFG_OFS_IRQ_STAT, 32'h1);
    @(posedge clock_i);
    chk("irq cleared", 0, irq_o);
    bus(1, `IMUCFG_OFS_IRQ_MASK, 32'h0);
    poll(32'h2);
    chk("diag kind", 3, p[50:49]);
    chk("diag data", subsys_status_i, p[31:16]);
    @(posedge clock_i);
    chk("irq masked", 0, irq_o);
    bus(0, 6'h3c, 0);
    chk("unmapped read", 0, rd);
    $display("test poll and interrupt done");
    // filters are written whole, then gyro byte only; orientation goes to 23 and the out-of-range 24 is ignored
    v = rnd();
    bus(1, `IMUCFG_OFS_FILT, v);
    m_filt = v[23:0];
    v = rnd();
    bus(1, `IMUCFG_OFS_FILT, v, 4'h1);
    m_filt[7:0] = v[7:0];
    bus(1, `IMUCFG_OFS_ORIENT, 23);
    m_orient = 23;
    bus(1, `IMUCFG_OFS_ORIENT, 24);
    chk_cfg();
    $display("test settings done");
    setctrl(2, 1, 7);
    poll(32'h1);
    v = rnd() | 32'h8000;
    gyro_delta_i <= v[15:0];
    repeat (10 * BASE + BASE / 2) @(posedge clock_i);
    gyro_delta_i <= '0;
    poll(32'h1);
    chk("delta format", 1, p[48]);
    e = (p[15:0] == 16'(v * 10)) ? 16'(v * 10) : 16'(v * 11);
    chk("delta sum", e, p[15:0]);
    $display("test delta done");
    setctrl(2, 0, 7);
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      a = v[3:0] & v[7:4];
      e = (i == 0) ? 32'h0 : {29'h0, v[10:8]};
      // the fatal flag stays set once any error has been seen
      m_fatal = m_fatal | (|e[2:0]);
      hw_error_i <= e[2:0];
      alert_i <= v[3:0];
      bus(1, `IMUCFG_OFS_ALERT_EN, v[7:4]);
      e = {16'h0, 3'h0, a[3:0], |a, 4'h0, e[2:0], m_fatal};
      poll(32'h1);
      chk("test word", e, p[47:32]);
      bus(0, `IMUCFG_OFS_BIT_WORD, 0);
      chk("test word reg", e, rd);
    end
    bus(0, `IMUCFG_OFS_FAULT_IN, 0);
    chk("fault input reg", {16'h0, subsys_status_i}, rd);
    bus(0, `IMUCFG_OFS_PKT_CNT, 0);
    chk("packet counter", host.n_pkt, rd);
    $display("test word done");
    results();
  end
endmodule

// ---- imucfg_accum.sv ----
// one wrap-around delta accumulator, restarted from the same-cycle sample (or zero without one) when a measurement packet is sent
// assumes sample_i pulses at the base processing rate
`timescale 1ns/10ps
module imucfg_accum #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             sample_i,
  input  wire logic [WIDTH-1:0] value_i,
  input  wire logic             take_i,
  output logic      [WIDTH-1:0] sum_o
);
  logic [WIDTH-1:0] sum_reg;

  // the sum wraps on overflow; the snapshot carries the sum before take
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sum_reg <= '0;
    end else if (take_i) begin
      sum_reg <= sample_i ? value_i : '0;
    end else if (sample_i) begin
      sum_reg <= sum_reg + value_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sum_o <= '0;
    end else if (take_i) begin
      sum_o <= sum_reg;
    end
  end
endmodule

// ---- imucfg_consts.svh ----
// constants for the output configuration and built-in-test block
// assumes a 100 MHz system clock and a 32-bit register bus
`ifndef IMUCFG_CONSTS_SVH
`define IMUCFG_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define IMUCFG_OFS_CTRL      6'h00
`define IMUCFG_OFS_FILT      6'h04
`define IMUCFG_OFS_ORIENT    6'h08
`define IMUCFG_OFS_ALERT_EN  6'h0c
`define IMUCFG_OFS_FAULT_IN  6'h10
`define IMUCFG_OFS_BIT_WORD  6'h14
`define IMUCFG_OFS_IRQ_STAT  6'h18
`define IMUCFG_OFS_IRQ_MASK  6'h1c
`define IMUCFG_OFS_CMD       6'h20
`define IMUCFG_OFS_PKT_CNT   6'h24

// ****************************************
// control field positions
// ****************************************
`define IMUCFG_CTRL_BAUD_LSB  0
`define IMUCFG_CTRL_FMT_BIT   2
`define IMUCFG_CTRL_RATE_LSB  4

// ****************************************
// reset values and orientation code count
// ****************************************
`define IMUCFG_BAUD_RST     2'h2
`define IMUCFG_RATE_RST     3'h0
`define IMUCFG_FILT_RST     8'h19
`define IMUCFG_ORIENT_RST   5'h00
`define IMUCFG_ALERT_RST    4'h8
`define IMUCFG_ORIENT_COUNT 5'h18

// ****************************************
// timing
// ****************************************
`define IMUCFG_CLK_HZ       100000000
`define IMUCFG_BASE_HZ      100
`define IMUCFG_BASE_CYCLES  (`IMUCFG_CLK_HZ / `IMUCFG_BASE_HZ)

// ****************************************
// test word bits
// ****************************************
`define IMUCFG_BIT_FATAL    0
`define IMUCFG_BIT_SUMMARY  8

// ****************************************
// interrupt bits
// ****************************************
`define IMUCFG_IRQ_PKT      0
`define IMUCFG_IRQ_FATAL    1
`define IMUCFG_IRQ_ALERT    2
`endif

// ---- imucfg_host_model.sv ----
// host side of the measurement stream: logs every packet with its cycle stamp
// assumes packets arrive as one-cycle strobes on the block's packet outputs
`timescale 1ns/10ps
module imucfg_host_model (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        pkt_valid_i,
  input  wire logic [1:0]  pkt_kind_i,
  input  wire logic        pkt_delta_i,
  input  wire logic [15:0] pkt_bit_word_i,
  input  wire logic [15:0] pkt_gyro_sum_i,
  input  wire logic [15:0] pkt_diag_i
);
  // ****************************************
  // packet log
  // ****************************************
  longint      cyc = 0;
  longint      t_q[$];
  logic [63:0] p_q[$];
  int          n_pkt = 0;

  // the bench polls delta packets with bit 15 set on purpose, to see the sums wrap
  always @(posedge clock_i) begin
    cyc <= sys_rst_i ? 0 : cyc + 1;
    if (pkt_valid_i === 1'b1) begin
      t_q.push_back(cyc);
      n_pkt <= n_pkt + 1;
      p_q.push_back({13'h0, pkt_kind_i, pkt_delta_i, pkt_bit_word_i, pkt_diag_i, pkt_gyro_sum_i});
    end
  end
endmodule

// ---- imucfg_pkg.sv ----
// types for the output configuration and built-in-test block
// assumes imucfg_consts.svh for numeric values
package imucfg_pkg;
  typedef enum logic [1:0] {
    IMUCFG_BAUD_9600  = 2'h0,
    IMUCFG_BAUD_19200 = 2'h1,
    IMUCFG_BAUD_38400 = 2'h2,
    IMUCFG_BAUD_57600 = 2'h3
  } imucfg_baud_e;

  typedef enum logic [2:0] {
    IMUCFG_RATE_100 = 3'h0,
    IMUCFG_RATE_50  = 3'h1,
    IMUCFG_RATE_25  = 3'h2,
    IMUCFG_RATE_20  = 3'h3,
    IMUCFG_RATE_10  = 3'h4,
    IMUCFG_RATE_5   = 3'h5,
    IMUCFG_RATE_2   = 3'h6,
    IMUCFG_RATE_QUIET = 3'h7
  } imucfg_rate_e;

  typedef enum logic [1:0] {
    IMUCFG_PKT_NONE  = 2'h0,
    IMUCFG_PKT_MEAS  = 2'h1,
    IMUCFG_PKT_DIAG  = 2'h3
  } imucfg_pkt_e;
endpackage

// ---- imucfg_top.sv ----
// output configuration, packet scheduling and built-in-test word
// assumes an Avalon-MM master on the register side, all synchronous
`timescale 1ns/10ps
`include "imucfg_consts.svh"

module imucfg_top
  import imucfg_pkg::*;
#(
  parameter int ACC_WIDTH  = 16,
  parameter int BASE_CYCLES = `IMUCFG_BASE_CYCLES
) (
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [5:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic [ACC_WIDTH-1:0]   gyro_delta_i,
  input  wire logic [2:0]             hw_error_i,
  input  wire logic [3:0]             alert_i,
  input  wire logic [15:0]            subsys_status_i,
  output logic      [1:0]             baud_sel_o,
  output logic      [7:0]             gyro_filt_o,
  output logic      [7:0]             accel_xy_filt_o,
  output logic      [7:0]             accel_z_filt_o,
  output logic      [4:0]             orient_o,
  output logic                        pkt_valid_o,
  output logic      [1:0]             pkt_kind_o,
  output logic                        pkt_delta_o,
  output logic      [15:0]            pkt_bit_word_o,
  output logic      [ACC_WIDTH-1:0]   pkt_gyro_sum_o,
  output logic      [15:0]            pkt_diag_o,
  output logic                        irq_o
);
  // ****************************************
  // registers
  // ****************************************
  imucfg_baud_e       baud_reg;
  logic               fmt_delta_reg;
  imucfg_rate_e       rate_reg;
  logic [7:0]         gyro_filt_reg;
  logic [7:0]         accel_xy_filt_reg;
  logic [7:0]         accel_z_filt_reg;
  logic [4:0]         orient_reg;
  logic [3:0]         alert_en_reg;
  logic               fatal_latch_reg;
  logic [2:0]         irq_stat_reg;
  logic [2:0]         irq_mask_reg;
  logic [15:0]        pkt_cnt_reg;
  logic [31:0]        base_cnt_reg;
  logic [5:0]         div_cnt_reg;
  logic               ack_reg;
  logic [15:0]        bit_word;
  logic               alert_summary_flag;
  logic               fatal_fault_flag;
  logic               base_tick;
  logic               rate_tick;
  logic               wr_stb;
  logic               rd_stb;
  logic               poll_meas;
  logic               poll_diag;
  logic               send_meas;
  logic               meas_due;
  logic               meas_pend_reg;
  logic [5:0]         div_max;

  // one wait cycle per access keeps read data registered
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_stb = avs_write_i & ack_reg;
  assign rd_stb = avs_read_i & ~ack_reg;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
    end
  end

  // ****************************************
  // configuration writes
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      baud_reg      <= imucfg_baud_e'(`IMUCFG_BAUD_RST);
      fmt_delta_reg <= 1'b0;
      rate_reg      <= imucfg_rate_e'(`IMUCFG_RATE_RST);
    end else if (wr_stb && avs_address_i == `IMUCFG_OFS_CTRL && avs_byteenable_i[0]) begin
      baud_reg      <= imucfg_baud_e'(avs_writedata_i[`IMUCFG_CTRL_BAUD_LSB +: 2]);
      fmt_delta_reg <= avs_writedata_i[`IMUCFG_CTRL_FMT_BIT];
      rate_reg      <= imucfg_rate_e'(avs_writedata_i[`IMUCFG_CTRL_RATE_LSB +: 3]);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gyro_filt_reg     <= `IMUCFG_FILT_RST;
      accel_xy_filt_reg <= `IMUCFG_FILT_RST;
      accel_z_filt_reg  <= `IMUCFG_FILT_RST;
    end else if (wr_stb && avs_address_i == `IMUCFG_OFS_FILT) begin
      if (avs_byteenable_i[0]) begin
        gyro_filt_reg <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        accel_xy_filt_reg <= avs_writedata_i[15:8];
      end
      if (avs_byteenable_i[2]) begin
        accel_z_filt_reg <= avs_writedata_i[23:16];
      end
    end
  end

  // out-of-range orientation codes are ignored, keeping the old setting
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      orient_reg <= `IMUCFG_ORIENT_RST;
    end else if (wr_stb && avs_address_i == `IMUCFG_OFS_ORIENT && avs_byteenable_i[0]
                 && avs_writedata_i[4:0] < `IMUCFG_ORIENT_COUNT) begin
      orient_reg <= avs_writedata_i[4:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      alert_en_reg <= `IMUCFG_ALERT_RST;
    end else if (wr_stb && avs_address_i == `IMUCFG_OFS_ALERT_EN && avs_byteenable_i[0]) begin
      alert_en_reg <= avs_writedata_i[3:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_mask_reg <= 3'h0;
    end else if (wr_stb && avs_address_i == `IMUCFG_OFS_IRQ_MASK && avs_byteenable_i[0]) begin
      irq_mask_reg <= avs_writedata_i[2:0];
    end
  end

  // ****************************************
  // built-in-test word
  // ****************************************
  // a fatal fault is sticky until reset: the unit is no longer trusted
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      fatal_latch_reg <= 1'b0;
    end else if (|hw_error_i) begin
      fatal_latch_reg <= 1'b1;
    end
  end

  assign fatal_fault_flag   = fatal_latch_reg | (|hw_error_i);
  assign alert_summary_flag = |(alert_i & alert_en_reg);
  assign bit_word = {3'h0, alert_i & alert_en_reg, alert_summary_flag,
                     4'h0, hw_error_i, fatal_fault_flag};

  // ****************************************
  // packet scheduling
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      base_cnt_reg <= 32'h0;
    end else if (base_tick) begin
      base_cnt_reg <= 32'h0;
    end else begin
      base_cnt_reg <= base_cnt_reg + 32'h1;
    end
  end
  assign base_tick = (base_cnt_reg == 32'(BASE_CYCLES - 1));

  always_comb begin
    case (rate_reg)
      IMUCFG_RATE_100: div_max = 6'h00;
      IMUCFG_RATE_50:  div_max = 6'h01;
      IMUCFG_RATE_25:  div_max = 6'h03;
      IMUCFG_RATE_20:  div_max = 6'h04;
      IMUCFG_RATE_10:  div_max = 6'h09;
      IMUCFG_RATE_5:   div_max = 6'h13;
      IMUCFG_RATE_2:   div_max = 6'h31;
      default:         div_max = 6'h00;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      div_cnt_reg <= 6'h0;
    end else if (base_tick) begin
      div_cnt_reg <= (div_cnt_reg >= div_max) ? 6'h0 : div_cnt_reg + 6'h1;
    end
  end

  assign rate_tick = base_tick && div_cnt_reg >= div_max && rate_reg != IMUCFG_RATE_QUIET;
  assign poll_meas = wr_stb && avs_address_i == `IMUCFG_OFS_CMD && avs_writedata_i[0];
  assign poll_diag = wr_stb && avs_address_i == `IMUCFG_OFS_CMD && avs_writedata_i[1];
  assign meas_due  = rate_tick | poll_meas | meas_pend_reg;
  // a diagnostic request takes the packet slot; the measurement follows one cycle later,
  // so no stream packet is lost and the sums are never cleared unsent
  assign send_meas = meas_due & ~poll_diag;

  // requests need two bus cycles each, so the deferred packet never waits twice
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meas_pend_reg <= 1'b0;
    end else begin
      meas_pend_reg <= meas_due & poll_diag;
    end
  end

  imucfg_accum #(
    .WIDTH (ACC_WIDTH)
  ) u_gyro_accum (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .sample_i  (base_tick),
    .value_i   (gyro_delta_i),
    .take_i    (send_meas),
    .sum_o     (pkt_gyro_sum_o)
  );

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pkt_valid_o    <= 1'b0;
      pkt_kind_o     <= IMUCFG_PKT_NONE;
      pkt_delta_o    <= 1'b0;
      pkt_bit_word_o <= 16'h0;
      pkt_diag_o     <= 16'h0;
    end else begin
      pkt_valid_o <= send_meas | poll_diag;
      if (poll_diag) begin
        pkt_kind_o <= IMUCFG_PKT_DIAG;
        pkt_diag_o <= subsys_status_i;
        pkt_bit_word_o <= bit_word;
      end else if (send_meas) begin
        pkt_kind_o     <= IMUCFG_PKT_MEAS;
        pkt_delta_o    <= fmt_delta_reg;
        pkt_bit_word_o <= bit_word;
      end else begin
        pkt_kind_o <= IMUCFG_PKT_NONE;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pkt_cnt_reg <= 16'h0;
    end else if (send_meas | poll_diag) begin
      pkt_cnt_reg <= pkt_cnt_reg + 16'h1;
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~((wr_stb && avs_address_i == `IMUCFG_OFS_IRQ_STAT)
                        ? avs_writedata_i[2:0] : 3'h0))
                      | {alert_summary_flag, fatal_fault_flag, send_meas | poll_diag};
    end
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // ****************************************
  // read back
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (rd_stb) begin
      case (avs_address_i)
        `IMUCFG_OFS_CTRL:     avs_readdata_o <= {25'h0, rate_reg, 1'b0, fmt_delta_reg, baud_reg};
        `IMUCFG_OFS_FILT:     avs_readdata_o <= {8'h0, accel_z_filt_reg, accel_xy_filt_reg, gyro_filt_reg};
        `IMUCFG_OFS_ORIENT:   avs_readdata_o <= {27'h0, orient_reg};
        `IMUCFG_OFS_ALERT_EN: avs_readdata_o <= {28'h0, alert_en_reg};
        `IMUCFG_OFS_FAULT_IN: avs_readdata_o <= {16'h0, subsys_status_i};
        `IMUCFG_OFS_BIT_WORD: avs_readdata_o <= {16'h0, bit_word};
        `IMUCFG_OFS_IRQ_STAT: avs_readdata_o <= {29'h0, irq_stat_reg};
        `IMUCFG_OFS_IRQ_MASK: avs_readdata_o <= {29'h0, irq_mask_reg};
        `IMUCFG_OFS_PKT_CNT:  avs_readdata_o <= {16'h0, pkt_cnt_reg};
        default:              avs_readdata_o <= 32'h0;
      endcase
    end
  end

  assign baud_sel_o      = baud_reg;
  assign gyro_filt_o     = gyro_filt_reg;
  assign accel_xy_filt_o = accel_xy_filt_reg;
  assign accel_z_filt_o  = accel_z_filt_reg;
  assign orient_o        = orient_reg;

  // ****************************************
  // checks
  // ****************************************
  quiet_no_stream_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (rate_reg == IMUCFG_RATE_QUIET && !poll_meas && !poll_diag && !meas_pend_reg) |=> !pkt_valid_o)
    else $error("packet sent while quiet without request");
  poll_answers_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    poll_meas |-> ##[1:2] (pkt_valid_o && pkt_kind_o == IMUCFG_PKT_MEAS))
    else $error("poll not answered in time");
  diag_answers_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    poll_diag |=> pkt_kind_o == IMUCFG_PKT_DIAG && pkt_diag_o == $past(subsys_status_i))
    else $error("diagnostic packet wrong");
  fatal_bit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (|hw_error_i && send_meas) |=> pkt_bit_word_o[`IMUCFG_BIT_FATAL])
    else $error("fatal flag missing");
  fatal_sticky_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    fatal_latch_reg |=> fatal_latch_reg)
    else $error("fatal flag dropped");
  summary_bit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    send_meas |=> pkt_bit_word_o[`IMUCFG_BIT_SUMMARY] == |($past(alert_i) & $past(alert_en_reg)))
    else $error("alert summary wrong");
  format_follows_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    send_meas |=> pkt_delta_o == $past(fmt_delta_reg))
    else $error("packet format wrong");
  orient_range_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    orient_reg < `IMUCFG_ORIENT_COUNT)
    else $error("orientation out of range");
  wait_one_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("slave waited too long");
  stream_c: cover property (@(posedge clock_i) disable iff (sys_rst_i) rate_tick ##1 pkt_valid_o);
  poll_c:   cover property (@(posedge clock_i) disable iff (sys_rst_i) poll_meas && fmt_delta_reg);
  diag_c:   cover property (@(posedge clock_i) disable iff (sys_rst_i) poll_diag);
  irq_c:    cover property (@(posedge clock_i) disable iff (sys_rst_i) irq_o);
endmodule
